// ===== osc_pkg.sv
// shared constants and types for the oscillator source and start-up block
package osc_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_NS = 10;
  localparam int SLOW_HZ = 31_000;
  localparam int FAST_HZ = 8_000_000;
  localparam int TWARM_NS = 2000;
  localparam int DRIFT_NS = 1000;
  localparam int XTAL_COUNT = 1024;
  localparam int XTAL_W = 11;
  localparam int WARM_W = 8;
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] SLOW_DIV_CYC = DIV_W'(CLK_HZ / SLOW_HZ);
  localparam logic [DIV_W-1:0] DRIFT_CYC = DIV_W'(DRIFT_NS / CLK_NS);
  localparam logic [WARM_W-1:0] WARM_CYC = WARM_W'((TWARM_NS + CLK_NS - 1) / CLK_NS);
  // phase increment of a 16-bit accumulator, scaled down to stay inside 32 bits
  localparam logic [15:0] FAST_INC = 16'((FAST_HZ / 1000) * 65536 / (CLK_HZ / 1000));
  localparam int TRIM_SHIFT = 5;

  // ==========================================================================
  // register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIM = 8'h04;
  localparam int CTRL_FREQ_LSB = 4;
  localparam int CTRL_EXT_RUN_BIT = 3;
  localparam int CTRL_FAST_OK_BIT = 2;
  localparam int CTRL_SLOW_OK_BIT = 1;
  localparam int CTRL_SCS_BIT = 0;
  localparam logic [2:0] FREQ_RST = 3'h6;
  localparam logic [2:0] FREQ_SLOW = 3'h0;
  localparam logic SCS_RST = 1'b0;
  localparam logic [4:0] TRIM_RST = 5'h00;

  // ==========================================================================
  // configured clock source
  typedef enum logic [2:0] {
    LOW_GAIN_CRYSTAL_MODE = 3'h0,
    MEDIUM_GAIN_CRYSTAL_MODE = 3'h1,
    HIGH_GAIN_CRYSTAL_MODE = 3'h2,
    EXTERNAL_LOGIC_CLOCK_MODE = 3'h3,
    INTERNAL_WITH_DIVIDED_OUT_MODE = 3'h4,
    INTERNAL_BOTH_PINS_FREE_MODE = 3'h5,
    RESISTOR_CAPACITOR_PIN_MODE = 3'h6,
    RESISTOR_CAPACITOR_DIVIDED_OUT_MODE = 3'h7
  } osc_mode_t;

  typedef enum logic [4:0] {
    ST_BOOT = 5'h01,
    ST_XTAL = 5'h02,
    ST_WARM = 5'h04,
    ST_RUN = 5'h08,
    ST_SLEEP = 5'h10
  } start_state_t;

endpackage : osc_pkg

// ===== tick_divider.sv
// free-running divider that emits a one-cycle enable every period cycles
`timescale 1ns/1ns
module tick_divider #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [W-1:0] period,
  // enable pulse
  output logic tick
);

  logic [W-1:0] cnt_r;
  logic wrap;

  assign wrap = (cnt_r == period - W'(1));

  always_ff @(posedge clk) begin
    if (!rst_b || !run) begin
      cnt_r <= '0;
    end else if (wrap) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick <= 1'b0;
    end else begin
      tick <= run && wrap;
    end
  end

endmodule : tick_divider

// ===== startup_counter.sv
// counts oscillation edges up to a terminal count and then reports done
`timescale 1ns/1ns
module startup_counter #(
  parameter int COUNT = 1024,
  parameter int W = 11
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic restart,
  input wire logic edge_seen,
  // status
  output logic done
);

  logic [W-1:0] cnt_r;

  assign done = (cnt_r == W'(COUNT));

  always_ff @(posedge clk) begin
    if (!rst_b || restart) begin
      cnt_r <= '0;
    end else if (edge_seen && !done) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

endmodule : startup_counter

// ===== osc_source_ctrl.sv
// oscillator source selection, start-up sequencing and pin control
`timescale 1ns/1ns
module osc_source_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration word
  input wire logic [2:0] cfg_mode,
  input wire logic two_speed_startup_enable,
  input wire logic power_up_delay_timer_enable,
  input wire logic slow_keep_alive,
  // power sequencing
  input wire logic power_up_delay_expired,
  input wire logic sleep_req,
  input wire logic wake_evt,
  // core side
  output logic exec_hold,
  output logic sys_tick,
  output logic fast_osc_en,
  output logic slow_osc_en,
  output logic slow_tick,
  output logic [4:0] fast_trim_applied,
  // oscillator pins
  input wire logic crystal_input_pin_in,
  output logic crystal_input_pin_out,
  output logic crystal_input_pin_oe,
  input wire logic crystal_output_pin_in,
  output logic crystal_output_pin_out,
  output logic crystal_output_pin_oe,
  // port logic for released pins
  input wire logic gp_in_pin_out,
  input wire logic gp_in_pin_oe,
  input wire logic gp_out_pin_out,
  input wire logic gp_out_pin_oe,
  output logic gp_in_pin_in,
  output logic gp_out_pin_in,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  // ==========================================================================
  // declarations
  osc_pkg::osc_mode_t mode;
  osc_pkg::start_state_t state_r, state_nxt, launch;
  logic [2:0] freq_r;
  logic scs_r;
  logic [4:0] trim_r;
  logic [4:0] trim_app_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic acc;
  logic [31:0] rd_val;
  logic [1:0] pin_s1_r, pin_s2_r;
  logic xin_d_r;
  logic ext_edge;
  logic xtal_mode, int_mode, use_int;
  logic [15:0] phase_r;
  logic [16:0] phase_sum;
  logic [15:0] fast_inc;
  logic fast_tick_r;
  logic [6:0] post_cnt_r;
  logic [6:0] post_mask;
  logic int_tick, src_tick, pin_tick;
  logic [1:0] osc_stable;
  logic sel_stable;
  logic drift_tick;
  logic xt_done, xt_restart;
  logic [1:0] quarter_r;
  logic quarter_clock_output;

  assign mode = osc_pkg::osc_mode_t'(cfg_mode);
  assign xtal_mode = (mode == osc_pkg::LOW_GAIN_CRYSTAL_MODE)
                  || (mode == osc_pkg::MEDIUM_GAIN_CRYSTAL_MODE)
                  || (mode == osc_pkg::HIGH_GAIN_CRYSTAL_MODE);
  assign int_mode = (mode == osc_pkg::INTERNAL_WITH_DIVIDED_OUT_MODE)
                 || (mode == osc_pkg::INTERNAL_BOTH_PINS_FREE_MODE);
  assign use_int = scs_r || int_mode;

  // ==========================================================================
  // bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel && htrans[1] && hready;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= acc && hwrite && (haddr[31:8] == 24'h000000);
      wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      freq_r <= osc_pkg::FREQ_RST;
      scs_r <= osc_pkg::SCS_RST;
    end else if (wr_pend_r && wr_addr_r == osc_pkg::OFS_CTRL) begin
      freq_r <= hwdata[osc_pkg::CTRL_FREQ_LSB +: 3];
      scs_r <= hwdata[osc_pkg::CTRL_SCS_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      trim_r <= osc_pkg::TRIM_RST;
    end else if (wr_pend_r && wr_addr_r == osc_pkg::OFS_TRIM) begin
      trim_r <= hwdata[4:0];
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (haddr[31:8] == 24'h000000) begin
      case (haddr[7:0])
        osc_pkg::OFS_CTRL: begin
          rd_val[osc_pkg::CTRL_FREQ_LSB +: 3] = freq_r;
          rd_val[osc_pkg::CTRL_EXT_RUN_BIT] = (state_r == osc_pkg::ST_RUN) && !use_int;
          rd_val[osc_pkg::CTRL_FAST_OK_BIT] = osc_stable[0];
          rd_val[osc_pkg::CTRL_SLOW_OK_BIT] = osc_stable[1];
          rd_val[osc_pkg::CTRL_SCS_BIT] = scs_r;
        end
        osc_pkg::OFS_TRIM: begin
          rd_val[4:0] = trim_r;
        end
        default: begin
          rd_val = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data is captured in the address phase so it stands in the data phase
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata <= rd_val;
    end
  end

  // ==========================================================================
  // pin synchronisers: bit 0 input pin, bit 1 output pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      xin_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {crystal_output_pin_in, crystal_input_pin_in};
      pin_s2_r <= pin_s1_r;
      xin_d_r <= pin_s2_r[0];
    end
  end

  // an external clock that stops gives no edges, so nothing driven by ext_edge advances
  assign ext_edge = pin_s2_r[0] && !xin_d_r;
  assign gp_in_pin_in = pin_s2_r[0];
  assign gp_out_pin_in = pin_s2_r[1];

  // ==========================================================================
  // internal oscillators
  assign fast_osc_en = (freq_r != osc_pkg::FREQ_SLOW) && (use_int || two_speed_startup_enable)
                    && (state_r != osc_pkg::ST_SLEEP);
  assign slow_osc_en = ((freq_r == osc_pkg::FREQ_SLOW) && (use_int || two_speed_startup_enable)
                     && (state_r != osc_pkg::ST_SLEEP)) || power_up_delay_timer_enable || slow_keep_alive;

  // trim moves the increment in signed steps; sign extension wraps correctly
  assign fast_inc = osc_pkg::FAST_INC
                  + 16'({{11{trim_app_r[4]}}, trim_app_r} << osc_pkg::TRIM_SHIFT);
  assign phase_sum = {1'b0, phase_r} + {1'b0, fast_inc};

  always_ff @(posedge clk) begin
    if (!rst_b || !fast_osc_en) begin
      phase_r <= 16'h0000;
      fast_tick_r <= 1'b0;
    end else begin
      phase_r <= phase_sum[15:0];
      fast_tick_r <= phase_sum[16];
    end
  end

  // the slow oscillator has a fixed period; trim never reaches it
  tick_divider #(.W(osc_pkg::DIV_W)) u_slow (
    .clk(clk),
    .rst_b(rst_b),
    .run(slow_osc_en),
    .period(osc_pkg::SLOW_DIV_CYC),
    .tick(slow_tick)
  );

  tick_divider #(.W(osc_pkg::DIV_W)) u_drift (
    .clk(clk),
    .rst_b(rst_b),
    .run(1'b1),
    .period(osc_pkg::DRIFT_CYC),
    .tick(drift_tick)
  );

  // applied trim walks one step per drift tick; software sees no end flag
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      trim_app_r <= osc_pkg::TRIM_RST;
    end else if (drift_tick && trim_app_r != trim_r) begin
      if ($signed(trim_app_r) < $signed(trim_r)) begin
        trim_app_r <= trim_app_r + 5'h01;
      end else begin
        trim_app_r <= trim_app_r - 5'h01;
      end
    end
  end
  assign fast_trim_applied = trim_app_r;

  // warm-up: bit 0 fast, bit 1 slow
  for (genvar i = 0; i < 2; i++) begin : g_warm
    logic [osc_pkg::WARM_W-1:0] cnt_r;
    logic en;
    assign en = (i == 0) ? fast_osc_en : slow_osc_en;
    always_ff @(posedge clk) begin
      if (!rst_b || !en) begin
        cnt_r <= '0;
      end else if (cnt_r != osc_pkg::WARM_CYC) begin
        cnt_r <= cnt_r + osc_pkg::WARM_W'(1);
      end
    end
    assign osc_stable[i] = (cnt_r == osc_pkg::WARM_CYC);
  end

  assign sel_stable = (freq_r == osc_pkg::FREQ_SLOW) ? osc_stable[1] : osc_stable[0];

  // ==========================================================================
  // postscaler: 111 passes 8 MHz, each step down halves, 000 takes slow
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      post_cnt_r <= 7'h00;
    end else if (fast_tick_r) begin
      post_cnt_r <= post_cnt_r + 7'h01;
    end
  end

  assign post_mask = 7'h7F >> freq_r;
  assign int_tick = (freq_r == osc_pkg::FREQ_SLOW) ? slow_tick
                  : fast_tick_r && ((post_cnt_r & post_mask) == post_mask);
  assign src_tick = use_int ? int_tick : ext_edge;
  assign pin_tick = int_mode ? int_tick : ext_edge;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sys_tick <= 1'b0;
    end else begin
      sys_tick <= (state_r == osc_pkg::ST_RUN) && src_tick;
    end
  end

  // ==========================================================================
  // start-up sequencer
  always_comb begin
    if (use_int) begin
      launch = osc_pkg::ST_WARM;
    end else if (xtal_mode) begin
      launch = osc_pkg::ST_XTAL;
    end else begin
      launch = osc_pkg::ST_RUN;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      osc_pkg::ST_BOOT: begin
        if (!power_up_delay_timer_enable || power_up_delay_expired) begin
          state_nxt = launch;
        end
      end
      osc_pkg::ST_XTAL: begin
        if (xt_done) begin
          state_nxt = osc_pkg::ST_RUN;
        end
      end
      osc_pkg::ST_WARM: begin
        if (sel_stable) begin
          state_nxt = osc_pkg::ST_RUN;
        end
      end
      osc_pkg::ST_RUN: begin
        if (sleep_req) begin
          state_nxt = osc_pkg::ST_SLEEP;
        end
      end
      osc_pkg::ST_SLEEP: begin
        if (wake_evt) begin
          state_nxt = launch;
        end
      end
      default: begin
        state_nxt = osc_pkg::ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= osc_pkg::ST_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign xt_restart = (state_nxt == osc_pkg::ST_XTAL) && (state_r != osc_pkg::ST_XTAL);
  assign exec_hold = (state_r != osc_pkg::ST_RUN);

  startup_counter #(.COUNT(osc_pkg::XTAL_COUNT), .W(osc_pkg::XTAL_W)) u_xtal (
    .clk(clk),
    .rst_b(rst_b),
    .restart(xt_restart),
    .edge_seen(ext_edge && state_r == osc_pkg::ST_XTAL),
    .done(xt_done)
  );

  // ==========================================================================
  // quarter-rate clock and pin ownership
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      quarter_r <= 2'h0;
    end else if (pin_tick) begin
      quarter_r <= quarter_r + 2'h1;
    end
  end
  assign quarter_clock_output = quarter_r[1];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      crystal_input_pin_out <= 1'b0;
      crystal_input_pin_oe <= 1'b0;
      crystal_output_pin_out <= 1'b0;
      crystal_output_pin_oe <= 1'b0;
    end else begin
      crystal_input_pin_out <= int_mode && gp_in_pin_out;
      crystal_input_pin_oe <= int_mode && gp_in_pin_oe;
      case (mode)
        osc_pkg::RESISTOR_CAPACITOR_DIVIDED_OUT_MODE,
        osc_pkg::INTERNAL_WITH_DIVIDED_OUT_MODE: begin
          crystal_output_pin_out <= quarter_clock_output;
          crystal_output_pin_oe <= 1'b1;
        end
        osc_pkg::EXTERNAL_LOGIC_CLOCK_MODE,
        osc_pkg::RESISTOR_CAPACITOR_PIN_MODE,
        osc_pkg::INTERNAL_BOTH_PINS_FREE_MODE: begin
          crystal_output_pin_out <= gp_out_pin_out;
          crystal_output_pin_oe <= gp_out_pin_oe;
        end
        default: begin
          crystal_output_pin_out <= 1'b0;
          crystal_output_pin_oe <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_count_then_run;
    state_r == osc_pkg::ST_XTAL ##1 state_r == osc_pkg::ST_RUN;
  endsequence

  a_xtal_release: assert property (s_count_then_run |-> $past(xt_done))
    else $error("crystal count released early");
  a_hold_counting: assert property (state_r == osc_pkg::ST_XTAL |-> exec_hold && !sys_tick)
    else $error("execution not held during crystal count");
  a_logic_clk_nodelay: assert property (state_r == osc_pkg::ST_SLEEP && wake_evt && !use_int
    && mode == osc_pkg::EXTERNAL_LOGIC_CLOCK_MODE |=> state_r == osc_pkg::ST_RUN)
    else $error("logic clock mode added a start-up delay");
  a_warm_wait: assert property (state_r == osc_pkg::ST_WARM ##1 state_r == osc_pkg::ST_RUN
    |-> $past(sel_stable))
    else $error("internal clock used before warm-up");
  a_stopped_halts: assert property (state_r == osc_pkg::ST_RUN && !use_int && !ext_edge
    |=> !sys_tick)
    else $error("core advanced without an external edge");
  a_quarter_rc: assert property (mode == osc_pkg::RESISTOR_CAPACITOR_DIVIDED_OUT_MODE
    && $stable(mode) |=> crystal_output_pin_oe && crystal_output_pin_out == $past(quarter_r[1]))
    else $error("output pin not carrying quarter clock");
  a_pins_free: assert property (mode == osc_pkg::INTERNAL_BOTH_PINS_FREE_MODE && $stable(mode)
    |=> crystal_input_pin_oe == $past(gp_in_pin_oe)
    && crystal_output_pin_oe == $past(gp_out_pin_oe))
    else $error("pins not released to port logic");
  a_fast_enable: assert property (freq_r == osc_pkg::FREQ_SLOW |-> !fast_osc_en)
    else $error("fast oscillator on with slow choice");
  a_trim_drift: assert property ($changed(trim_app_r) |-> $past(drift_tick)
    && $past(trim_app_r) != $past(trim_r))
    else $error("trim applied without a drift step");
  a_reset_values: assert property ($past(!rst_b) |-> freq_r == osc_pkg::FREQ_RST
    && !scs_r && trim_r == osc_pkg::TRIM_RST)
    else $error("control bits wrong after reset");

endmodule : osc_source_ctrl

// ===== xtal_model.sv
// behavioural crystal, resonator, rc network or clock source on the oscillator pins
`timescale 1ns/1ns
module xtal_model #(
  parameter int HALF_NS = 20
) (
  // control from the bench
  input wire logic run,
  // pin levels
  input wire logic xout_oe,
  input wire logic xout_val,
  output logic xin,
  output logic xout
);
  logic last = 1'b0;
  // ==========================================================================
  // source
  // a stopped source rests low so no stray edge reaches the start-up count
  initial begin
    xin = 1'b0;
    forever begin
      #HALF_NS;
      xin = run ? ~xin : 1'b0;
    end
  end
  // ==========================================================================
  // output pin
  // nobody pulls this line, so an undriven pin shows the inverse of its last level
  always @(xout_oe or xout_val) begin
    if (xout_oe) begin
      last = xout_val;
    end
  end
  assign xout = xout_oe ? xout_val : ~last;
endmodule : xtal_model

// ===== oscillator_source_and_startup_tb.sv
// self-checking bench for the oscillator source and start-up block
`timescale 1ns/1ns
module oscillator_source_and_startup_tb;
  logic clk, rst_b = 1'b0, xrun = 1'b0, xin, xout, xin_lvl, hready;
  logic [2:0] cfg_mode = 3'h0;
  logic two_speed_startup_enable = 1'b0, power_up_delay_timer_enable = 1'b0, slow_keep_alive = 1'b0;
  logic power_up_delay_expired = 1'b0, sleep_req = 1'b0, wake_evt = 1'b0;
  logic exec_hold, fast_osc_en, slow_tick, hreadyout, hresp, sys_tick, gp_out_pin_in;
  logic [4:0] fast_trim_applied;
  logic crystal_input_pin_out, crystal_input_pin_oe, crystal_output_pin_out, crystal_output_pin_oe;
  logic gp_in_pin_out = 1'b1, gp_in_pin_oe = 1'b1, gp_out_pin_out = 1'b0, gp_out_pin_oe = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  int err_count = 0, checked = 0, edges = 0;

  // ==========================================================================
  // clock, pins and instances
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  assign hready = hreadyout;
  assign xin_lvl = crystal_input_pin_oe ? crystal_input_pin_out : xin;
  always @(posedge xin) edges++;
  xtal_model i_src (.run(xrun), .xout_oe(crystal_output_pin_oe),
    .xout_val(crystal_output_pin_out), .xin(xin), .xout(xout));
  osc_source_ctrl i_dut (.clk, .rst_b, .cfg_mode, .two_speed_startup_enable, .power_up_delay_timer_enable,
    .slow_keep_alive, .power_up_delay_expired, .sleep_req, .wake_evt, .exec_hold,
    .sys_tick, .fast_osc_en, .slow_osc_en(), .slow_tick, .fast_trim_applied,
    .crystal_input_pin_in(xin_lvl), .crystal_input_pin_out, .crystal_input_pin_oe,
    .crystal_output_pin_in(xout), .crystal_output_pin_out, .crystal_output_pin_oe,
    .gp_in_pin_out, .gp_in_pin_oe, .gp_out_pin_out, .gp_out_pin_oe, .gp_in_pin_in(),
    .gp_out_pin_in, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout, .hresp, .hrdata);

  // ==========================================================================
  // shared tasks
  task automatic finish_test;
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic boot(input logic [2:0] m);
    @(posedge clk);
    cfg_mode <= m;
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
  endtask : boot

  task automatic wait_hold(input logic v, input int lim, output int n);
    n = 0;
    while (exec_hold !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_hold

  // ==========================================================================
  // scenarios
  task automatic t_xtal;
    int n;
    for (int m = 0; m < 3; m++) begin
      xrun = 1'b0;
      boot(m[2:0]);
      edges = 0;
      xrun = 1'b1;
      wait (edges == 1000);
      #1;
      chk(exec_hold, 1'b1);
      chk(crystal_output_pin_oe, 1'b0);
      wait_hold(1'b0, 8000, n);
      chk(edges >= 1024 && edges <= 1025, 1'b1);
    end
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    xrun = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(exec_hold, 1'b1);
    @(posedge clk);
    wake_evt <= 1'b1;
    @(posedge clk);
    wake_evt <= 1'b0;
    edges = 0;
    xrun = 1'b1;
    wait_hold(1'b0, 8000, n);
    chk(edges >= 1024 && edges <= 1025, 1'b1);
  endtask : t_xtal

  task automatic t_ext;
    int n, tk;
    power_up_delay_timer_enable <= 1'b1;
    gp_out_pin_out <= 1'b1;
    boot(osc_pkg::EXTERNAL_LOGIC_CLOCK_MODE);
    repeat (20) @(posedge clk);
    #1;
    chk(exec_hold, 1'b1);
    power_up_delay_expired <= 1'b1;
    wait_hold(1'b0, 20, n);
    chk(n <= 4, 1'b1);
    chk({crystal_input_pin_oe, crystal_output_pin_oe, crystal_output_pin_out}, 3'h3);
    repeat (4) @(posedge clk);
    #1;
    chk(gp_out_pin_in, 1'b1);
    // a stopped source must not advance the core; a running one gives one tick per edge
    tk = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      tk += sys_tick;
    end
    chk(tk, 0);
    xrun = 1'b1;
    tk = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      tk += sys_tick;
    end
    xrun = 1'b0;
    chk(tk >= 23 && tk <= 26, 1'b1);
    power_up_delay_timer_enable <= 1'b0;
    gp_out_pin_out <= 1'b0;
  endtask : t_ext

  task automatic t_pins;
    int n, tg;
    logic lo, hi;
    // the rc network on the input pin drives the divided-out count in mode 7
    xrun = 1'b1;
    for (int m = 4; m < 8; m++) begin
      boot(m[2:0]);
      wait_hold(1'b0, 400, n);
      if (m == 4) begin
        chk(n >= 198 && n <= 206, 1'b1);
      end
      tg = 0;
      repeat (400) begin
        lo = crystal_output_pin_out;
        @(posedge clk);
        #1;
        tg += (crystal_output_pin_out !== lo);
      end
      chk(crystal_input_pin_oe, m < 6);
      chk(crystal_output_pin_oe, 1'b1);
      lo = (m == 4) ? (tg >= 6 && tg <= 10) : (m == 7) ? (tg >= 48 && tg <= 52) : (tg == 0);
      chk(lo, 1'b1);
    end
  endtask : t_pins

  task automatic t_regs;
    int n, t0;
    boot(osc_pkg::EXTERNAL_LOGIC_CLOCK_MODE);
    bus(1'b0, 32'h0, 32'h0);
    chk(rd & ~32'h0000000E, 32'h60);
    bus(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 32'h100, 32'hFF);
    bus(1'b0, 32'h100, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 32'h0, 32'h01);
    #1;
    chk(fast_osc_en, 1'b0);
    bus(1'b1, 32'h0, 32'h71);
    #1;
    chk(fast_osc_en, 1'b1);
    repeat (250) @(posedge clk);
    bus(1'b0, 32'h0, 32'h0);
    chk(rd[2], 1'b1);
    bus(1'b1, 32'h0, 32'h70);
    #1;
    chk(fast_osc_en, 1'b0);
    two_speed_startup_enable <= 1'b1;
    @(posedge clk);
    #1;
    chk(fast_osc_en, 1'b1);
    two_speed_startup_enable <= 1'b0;
    bus(1'b1, 32'h4, 32'hFFFFFFFF);
    bus(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h1F);
    // let the applied trim settle first so the walk below has a known length
    n = 0;
    while (fast_trim_applied !== 5'h1F && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    bus(1'b1, 32'h4, 32'h0F);
    n = 0;
    while (fast_trim_applied !== 5'h0F && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n >= 1500 && n <= 1800, 1'b1);
    slow_keep_alive <= 1'b1;
    @(posedge slow_tick);
    t0 = $time;
    @(posedge slow_tick);
    chk(($time - t0) / 10, osc_pkg::SLOW_DIV_CYC);
  endtask : t_regs

  // ==========================================================================
  // sequence and watchdog
  initial begin
    t_regs();
    t_ext();
    t_pins();
    t_xtal();
    finish_test();
  end

  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule : oscillator_source_and_startup_tb
